// >>> hdl/iss_link_shift.sv
// Shift engine for synchronous serial mode with an external clock.
// Runs on the peer's clock, which stands still between frames; control
// levels arrive from the system domain and are synchronised here.
`timescale 1ns/10ps
`default_nettype none

module iss_link_shift (
	input wire logic link_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic enable_i,
	input wire logic msb_first_i,
	input wire logic tx_mode_i,
	input wire logic sda_i,
	input wire logic [7:0] tx_word_i,
	input wire logic tx_req_i,
	output logic tx_ack_o,
	output logic [7:0] rx_word_o,
	output logic rx_tgl_o,
	output logic sda_o,
	output logic busy_o
);

	logic [4:0] ctl_meta;
	logic [4:0] ctl_sync;
	logic [2:0] rcnt;
	logic [2:0] tcnt;
	logic [7:0] rx_sh;
	logic [7:0] tx_sh;
	logic [7:0] rx_next;
	logic l_ce;
	logic l_en;
	logic l_msb;
	logic l_txm;
	logic l_req;

	assign {l_ce, l_en, l_msb, l_txm, l_req} = ctl_sync;
	assign rx_next = l_msb ? {rx_sh[6:0], sda_i} : {sda_i, rx_sh[7:1]}; // see RULE_10
	assign busy_o = (rcnt != 3'h0) | (tcnt != 3'h0);

	// Control levels and request toggle into the link domain
	always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl_meta <= 5'h00;
			ctl_sync <= 5'h00;
		end else begin
			ctl_meta <= {ce_i, enable_i, msb_first_i, tx_mode_i, tx_req_i};
			ctl_sync <= ctl_meta;
		end
	end

	// Sample on rising edge; eight bits make a byte
	always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rcnt <= 3'h0;
			rx_sh <= iss_pkg::RST_DATA;
			rx_word_o <= iss_pkg::RST_DATA;
			rx_tgl_o <= 1'b0;
		end else if (l_ce && l_en) begin
			rx_sh <= rx_next; // see RULE_09
			rcnt <= rcnt + 3'h1;
			if (rcnt == iss_pkg::LAST_BIT_IDX) begin
				rx_word_o <= rx_next; // see RULE_22
				rx_tgl_o <= ~rx_tgl_o;
			end
		end
	end

	// Drive on falling edge; take a new word at each frame start
	always_ff @(negedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tcnt <= 3'h0;
			tx_sh <= iss_pkg::RST_DATA;
			tx_ack_o <= 1'b0;
			sda_o <= iss_pkg::RST_LINE;
		end else if (l_ce && l_en && l_txm) begin
			tcnt <= tcnt + 3'h1;
			if (tcnt == 3'h0) begin
				// Word is stable: the request toggle only moves after it is written
				if (l_req != tx_ack_o) begin
					tx_ack_o <= ~tx_ack_o;
				end
				sda_o <= l_msb ? tx_word_i[7] : tx_word_i[0]; // see RULE_09
				tx_sh <= l_msb ? {tx_word_i[6:0], 1'b0} : {1'b0, tx_word_i[7:1]};
			end else begin
				sda_o <= l_msb ? tx_sh[7] : tx_sh[0]; // see RULE_10
				tx_sh <= l_msb ? {tx_sh[6:0], 1'b0} : {1'b0, tx_sh[7:1]};
			end
		end
	end

endmodule : iss_link_shift

`default_nettype wire

// >>> hdl/iss_noise_filter.sv
// Input noise canceller for the clock and data pins.
// Assumes raw pin levels, asynchronous to clk_i; outputs are clk_i-synchronous.
`timescale 1ns/10ps
`default_nettype none

module iss_noise_filter #(
	parameter int W = 2
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);

	logic [W-1:0] meta;
	logic [W-1:0] sync;
	logic [W-1:0] latch_a;
	logic [W-1:0] latch_b;

	// Two-flop synchroniser, then two cascaded latches with match detect
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= {W{iss_pkg::RST_LINE}};
			sync <= {W{iss_pkg::RST_LINE}};
			latch_a <= {W{iss_pkg::RST_LINE}};
			latch_b <= {W{iss_pkg::RST_LINE}};
		end else if (ce_i) begin
			meta <= pin_i;
			sync <= meta;
			latch_a <= sync; // see RULE_19
			latch_b <= latch_a;
		end
	end

	// Level moves only when both latches agree, otherwise hold
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			level_o <= {W{iss_pkg::RST_LINE}};
		end else if (ce_i) begin
			for (int i = 0; i < W; i++) begin
				if (latch_a[i] == latch_b[i]) begin
					level_o[i] <= latch_b[i]; // see RULE_19
				end
			end
		end
	end

endmodule : iss_noise_filter

`default_nettype wire

// >>> hdl/iss_pkg.sv
// Shared constants and state types for the two-wire slave-receive and
// synchronous serial block.
// Assumes a 250 MHz system clock; all pin timing is counted in its cycles.
//
// How it works
// RULE_01 - Software enables transfer, sets options, clears transmit and master before addressing.
// RULE_02 - On own-address match, drive ack level from eighth to ninth falling clock.
// RULE_03 - Address match sets receive-full together; software discards that first read.
// RULE_04 - Slave receive holds clock low at eighth fall while receive-full stays set.
// RULE_05 - Ack level changed before a data read applies only to following frames.
// RULE_06 - Software sets ack level one before reading penultimate byte to nack last.
// RULE_07 - Format select one switches to clock-synchronous serial instead of two-wire protocol.
// RULE_08 - Synchronous mode: master drives the clock, otherwise the clock comes from outside.
// RULE_09 - Synchronous data changes between falling edges and is sampled on rising edges.
// RULE_10 - Bit order select picks most or least significant bit first.
// RULE_11 - In synchronous standby the data line shows the programmed standby level. The code drives it only while transmit select is set.
// RULE_12 - Setting transmit select in synchronous mode enters transmit and sets transmit-empty.
// RULE_13 - Written transmit byte moves to shift register and transmit-empty sets again.
// RULE_14 - Software leaves synchronous transmit only while transmit-empty reads one.
// RULE_15 - In synchronous receive, master select one starts the generated receive clock.
// RULE_16 - Each received byte copies to receive data and sets receive-full; master continues.
// RULE_17 - Byte ending while receive-full set flags overrun and keeps the older byte.
// RULE_18 - Master with receive-stop set halts clock high after the next byte.
// RULE_19 - Clock and data inputs pass two latches; level moves only when both agree. The external-clock shift engine takes sda_i and link_clk_i unfiltered.
// RULE_20 - Two-wire master watches the real clock level and stretches its high phase.
// RULE_21 - After releasing clock low, wait the monitoring time chosen by rate bits.
// RULE_22 - Every synchronous frame is exactly eight data bits with no acknowledge.

package iss_pkg;

	// Frame shape
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] ACK_BIT_NUM = 4'h8;
	localparam logic [2:0] LAST_BIT_IDX = 3'h7;

	// Reset values
	localparam logic RST_LINE = 1'b1;
	localparam logic [7:0] RST_DATA = 8'h00;

	// Clock timing; a half phase must outlast the five-cycle pin filter
	localparam real CLK_PERIOD_NS = 4.0;
	localparam int SCL_HALF_BASE_CYC = 8;

	// Clock monitoring times, in system clock periods
	localparam real MT_00_TCYC = 7.5;
	localparam real MT_01_TCYC = 19.5;
	localparam real MT_10_TCYC = 17.5;
	localparam real MT_11_TCYC = 41.5;
	localparam real MT_ALT_00_TCYC = 2.5;
	localparam real MT_ALT_01_TCYC = 8.5;
	localparam int MT_00_CYC = int'($ceil(MT_00_TCYC));
	localparam int MT_01_CYC = int'($ceil(MT_01_TCYC));
	localparam int MT_10_CYC = int'($ceil(MT_10_TCYC));
	localparam int MT_11_CYC = int'($ceil(MT_11_TCYC));
	localparam int MT_ALT_00_CYC = int'($ceil(MT_ALT_00_TCYC));
	localparam int MT_ALT_01_CYC = int'($ceil(MT_ALT_01_TCYC));

	// Slave receive states
	typedef enum logic [5:0] {
		SL_IDLE = 6'h01,
		SL_ADDR = 6'h02,
		SL_DATA = 6'h04,
		SL_ACK = 6'h08,
		SL_HOLD = 6'h10,
		SL_SKIP = 6'h20
	} iss_slv_state_t;

	// Clock generator states
	typedef enum logic [3:0] {
		CG_IDLE = 4'h1,
		CG_LOW = 4'h2,
		CG_WAIT = 4'h4,
		CG_HIGH = 4'h8
	} iss_cg_state_t;

endpackage : iss_pkg

// >>> hdl/iss_top.sv
// Two-wire slave receiver, synchronous serial engine and master clock
// generator with bit synchronisation. Control and status bits are ports.
// Assumes open-drain pins resolved outside; link_clk_i is the external
// serial clock used only in synchronous mode without master select.
`timescale 1ns/10ps
`default_nettype none

module iss_top #(
	parameter int DIV_W = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic xfer_enable_i,
	input wire logic format_select_i,
	input wire logic master_select_i,
	input wire logic transmit_select_i,
	input wire logic bit_order_select_i,
	input wire logic ack_level_bit_i,
	input wire logic rx_stop_request_i,
	input wire logic sda_level_out_i,
	input wire logic [3:0] clock_rate_select_i,
	input wire logic timing_half_select_i,
	input wire logic timing_alt_select_i,
	input wire logic [6:0] own_addr_i,
	input wire logic i2c_master_run_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_write_i,
	input wire logic rx_read_i,
	input wire logic overrun_clear_i,
	output logic [7:0] rx_data_o,
	output logic rx_full_flag_o,
	output logic tx_empty_flag_o,
	output logic overrun_flag_o,
	output logic busy_o
);

	// Refuse a divider too narrow for the slowest clock or longest wait
	if (DIV_W < 8) begin : g_div_check
		$error("iss_top: DIV_W must be at least 8");
	end

	logic scl_f;
	logic sda_f;
	logic scl_q;
	logic sda_q;
	logic [7:0] tx_data_reg;
	logic tx_sel_q;
	logic [7:0] link_tx_word;
	logic link_req;
	logic link_ack;
	logic [1:0] ack_sync;
	logic [2:0] rxt_sync;
	logic [7:0] link_rx_word;
	logic link_rx_tgl;
	logic link_sda;
	logic link_busy;
	iss_pkg::iss_slv_state_t slv_st;
	logic [3:0] slv_bits;
	logic [7:0] slv_sh;
	logic ack_next;
	logic ack_val;
	iss_pkg::iss_cg_state_t cg_st;
	logic [DIV_W-1:0] cg_cnt;
	logic [2:0] sm_bit;
	logic [7:0] shift_reg;
	logic sda_bit;
	logic rx_stopped;

	// Mode decode
	logic i2c_mode;
	logic sync_mode;
	logic slv_active;
	logic ext_mode;
	logic sm_mode;
	logic i2c_master;
	assign i2c_mode = xfer_enable_i & ~format_select_i;
	assign sync_mode = xfer_enable_i & format_select_i; // see RULE_07
	assign slv_active = i2c_mode & ~master_select_i;
	assign ext_mode = sync_mode & ~master_select_i; // see RULE_08
	assign sm_mode = sync_mode & master_select_i; // see RULE_08
	assign i2c_master = i2c_mode & master_select_i;

	// Pin noise canceller
	iss_noise_filter #(
		.W(2)
	) u_filter (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.pin_i({scl_i, sda_i}),
		.level_o({scl_f, sda_f})
	);

	// External-clock shift engine on the link's own clock
	iss_link_shift u_link (
		.link_clk_i(link_clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.enable_i(ext_mode),
		.msb_first_i(bit_order_select_i),
		.tx_mode_i(transmit_select_i),
		.sda_i(sda_i),
		.tx_word_i(link_tx_word),
		.tx_req_i(link_req),
		.tx_ack_o(link_ack),
		.rx_word_o(link_rx_word),
		.rx_tgl_o(link_rx_tgl),
		.sda_o(link_sda),
		.busy_o(link_busy)
	);

	// Filtered edges and bus conditions
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	assign scl_rise = scl_f & ~scl_q;
	assign scl_fall = ~scl_f & scl_q;
	assign start_cond = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_cond = scl_f & scl_q & ~sda_q & sda_f;

	// Clock generator timing
	logic [DIV_W-1:0] half_cyc;
	logic [DIV_W-1:0] mt_cyc;
	logic [DIV_W-1:0] mt_base;
	assign half_cyc = DIV_W'(({4'h0, clock_rate_select_i} + 8'h01)
		* 8'(iss_pkg::SCL_HALF_BASE_CYC));

	// Monitoring time picked by rate bits 3 and 2 and the modifier bits
	always_comb begin
		mt_base = DIV_W'(iss_pkg::MT_00_CYC);
		if (timing_alt_select_i && !clock_rate_select_i[3]) begin
			mt_base = clock_rate_select_i[2] ? DIV_W'(iss_pkg::MT_ALT_01_CYC)
				: DIV_W'(iss_pkg::MT_ALT_00_CYC);
		end else begin
			case (clock_rate_select_i[3:2])
				2'b00: mt_base = DIV_W'(iss_pkg::MT_00_CYC); // see RULE_21
				2'b01: mt_base = DIV_W'(iss_pkg::MT_01_CYC);
				2'b10: mt_base = DIV_W'(iss_pkg::MT_10_CYC);
				default: mt_base = DIV_W'(iss_pkg::MT_11_CYC);
			endcase
		end
		mt_cyc = timing_half_select_i ? DIV_W'({mt_base, 1'b0}) : mt_base;
	end

	// Byte completion events
	logic slv_fall8;
	logic addr_hit;
	logic slv_copy;
	logic sm_done;
	logic sm_rx_done;
	logic link_rx_ev;
	logic byte_ev;
	logic [7:0] byte_val;
	logic cg_start;
	logic shifter_free;
	logic tx_move;
	assign slv_fall8 = scl_fall & (slv_bits == iss_pkg::ACK_BIT_NUM);
	assign addr_hit = (slv_sh[7:1] == own_addr_i);
	assign slv_copy = slv_active & ((slv_st == iss_pkg::SL_ADDR & slv_fall8 & addr_hit)
		| (slv_st == iss_pkg::SL_DATA & slv_fall8 & ~rx_full_flag_o)
		| (slv_st == iss_pkg::SL_HOLD & ~rx_full_flag_o));
	assign sm_done = sm_mode & (cg_st == iss_pkg::CG_HIGH) & (cg_cnt == '0)
		& (sm_bit == iss_pkg::LAST_BIT_IDX);
	assign sm_rx_done = sm_done & ~transmit_select_i;
	assign link_rx_ev = ext_mode & ~transmit_select_i & (rxt_sync[2] ^ rxt_sync[1]);
	assign byte_ev = slv_copy | sm_rx_done | link_rx_ev;
	assign byte_val = slv_copy ? slv_sh : (sm_rx_done ? shift_reg : link_rx_word);
	assign shifter_free = ext_mode ? (link_req == ack_sync[1])
		: ((cg_st == iss_pkg::CG_IDLE) | sm_done);
	assign tx_move = sync_mode & transmit_select_i & tx_sel_q & ~tx_empty_flag_o & shifter_free;
	assign cg_start = (sm_mode & (transmit_select_i ? tx_move : ~rx_stopped))
		| (i2c_master & i2c_master_run_i); // see RULE_15
	assign busy_o = (cg_st != iss_pkg::CG_IDLE) | (slv_st != iss_pkg::SL_IDLE) | link_busy;

	// Edge history and crossings from the link domain
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scl_q <= iss_pkg::RST_LINE;
			sda_q <= iss_pkg::RST_LINE;
			ack_sync <= 2'h0;
			rxt_sync <= 3'h0;
		end else if (ce_i) begin
			scl_q <= scl_f;
			sda_q <= sda_f;
			ack_sync <= {ack_sync[0], link_ack};
			rxt_sync <= {rxt_sync[1:0], link_rx_tgl};
		end
	end

	// Transmit buffer and transmit-empty flag
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_data_reg <= iss_pkg::RST_DATA;
			tx_empty_flag_o <= 1'b0;
			tx_sel_q <= 1'b0;
			link_tx_word <= iss_pkg::RST_DATA;
			link_req <= 1'b0;
		end else if (ce_i) begin
			tx_sel_q <= sync_mode & transmit_select_i;
			if (tx_write_i) begin
				tx_data_reg <= tx_data_i;
			end
			if (tx_move && ext_mode) begin
				link_tx_word <= tx_data_reg; // word settles before the toggle is seen
				link_req <= ~link_req;
			end
			if ((sync_mode & transmit_select_i & ~tx_sel_q) || tx_move) begin
				tx_empty_flag_o <= 1'b1; // see RULE_12 RULE_13
			end else if (tx_write_i) begin
				tx_empty_flag_o <= 1'b0;
			end
		end
	end

	// Receive data, receive-full and overrun; a set beats a same-cycle clear
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_data_o <= iss_pkg::RST_DATA;
			rx_full_flag_o <= 1'b0;
			overrun_flag_o <= 1'b0;
		end else if (ce_i) begin
			if (byte_ev && (slv_copy || !rx_full_flag_o)) begin
				rx_data_o <= byte_val; // see RULE_03 RULE_16
			end
			rx_full_flag_o <= byte_ev | (rx_full_flag_o & ~rx_read_i); // see RULE_16
			overrun_flag_o <= (byte_ev & ~slv_copy & rx_full_flag_o)
				| (overrun_flag_o & ~overrun_clear_i); // see RULE_17
		end
	end

	// Slave receive sequencer
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			slv_st <= iss_pkg::SL_IDLE;
			slv_bits <= 4'h0;
			slv_sh <= iss_pkg::RST_DATA;
			ack_next <= 1'b0;
			ack_val <= 1'b1;
		end else if (ce_i) begin
			// Ack chosen before a read applies to the frame after the one read
			if (rx_read_i) begin
				ack_next <= ack_level_bit_i; // see RULE_05
			end
			if (!slv_active || stop_cond) begin
				slv_st <= iss_pkg::SL_IDLE;
			end else if (start_cond) begin
				slv_st <= iss_pkg::SL_ADDR;
				slv_bits <= 4'h0;
			end else begin
				if (scl_rise && (slv_st == iss_pkg::SL_ADDR || slv_st == iss_pkg::SL_DATA)) begin
					slv_sh <= {slv_sh[6:0], sda_f};
					slv_bits <= slv_bits + 4'h1;
				end
				case (slv_st)
					iss_pkg::SL_ADDR: begin
						if (slv_fall8) begin
							slv_st <= addr_hit ? iss_pkg::SL_ACK : iss_pkg::SL_SKIP;
							ack_val <= ack_level_bit_i; // see RULE_02
						end
					end
					iss_pkg::SL_DATA: begin
						if (slv_fall8) begin
							slv_st <= rx_full_flag_o ? iss_pkg::SL_HOLD : iss_pkg::SL_ACK;
							ack_val <= ack_next; // see RULE_05
						end
					end
					iss_pkg::SL_HOLD: begin
						if (!rx_full_flag_o) begin
							slv_st <= iss_pkg::SL_ACK; // see RULE_04
							ack_val <= ack_next;
						end
					end
					iss_pkg::SL_ACK: begin
						if (scl_fall) begin
							slv_st <= iss_pkg::SL_DATA; // ninth fall ends ack
							slv_bits <= 4'h0;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Clock generator, synchronous shifter and stop-after-byte latch
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cg_st <= iss_pkg::CG_IDLE;
			cg_cnt <= '0;
			sm_bit <= 3'h0;
			shift_reg <= iss_pkg::RST_DATA;
			sda_bit <= iss_pkg::RST_LINE;
			rx_stopped <= 1'b0;
		end else if (ce_i) begin
			if (!rx_stop_request_i) begin
				rx_stopped <= 1'b0;
			end
			if (!(sm_mode || i2c_master)) begin
				cg_st <= iss_pkg::CG_IDLE;
			end else begin
				case (cg_st)
					iss_pkg::CG_IDLE: begin
						if (cg_start) begin
							cg_st <= iss_pkg::CG_LOW;
							cg_cnt <= half_cyc - 1'b1;
							sm_bit <= 3'h0;
							if (tx_move) begin
								shift_reg <= tx_data_reg;
								sda_bit <= bit_order_select_i ? tx_data_reg[7] : tx_data_reg[0];
							end
						end
					end
					iss_pkg::CG_LOW: begin
						if (cg_cnt != '0) begin
							cg_cnt <= cg_cnt - 1'b1;
						end else if (i2c_master) begin
							cg_st <= iss_pkg::CG_WAIT; // release, then monitor
							cg_cnt <= mt_cyc - 1'b1; // see RULE_21
						end else begin
							cg_st <= iss_pkg::CG_HIGH;
							cg_cnt <= half_cyc - 1'b1;
							shift_reg <= bit_order_select_i ? {shift_reg[6:0], sda_f}
								: {sda_f, shift_reg[7:1]}; // see RULE_09 RULE_10
						end
					end
					iss_pkg::CG_WAIT: begin
						// A slave holding the line low stretches the high phase
						if (cg_cnt != '0) begin
							cg_cnt <= cg_cnt - 1'b1;
						end else if (scl_f) begin
							cg_st <= iss_pkg::CG_HIGH; // see RULE_20
							cg_cnt <= half_cyc - 1'b1;
						end
					end
					iss_pkg::CG_HIGH: begin
						if (cg_cnt != '0) begin
							cg_cnt <= cg_cnt - 1'b1;
						end else if (i2c_master) begin
							cg_st <= i2c_master_run_i ? iss_pkg::CG_LOW : iss_pkg::CG_IDLE;
							cg_cnt <= half_cyc - 1'b1;
						end else if (sm_bit == iss_pkg::LAST_BIT_IDX) begin
							sm_bit <= 3'h0; // see RULE_22
							cg_cnt <= half_cyc - 1'b1;
							if (transmit_select_i) begin
								cg_st <= tx_move ? iss_pkg::CG_LOW : iss_pkg::CG_IDLE;
								shift_reg <= tx_data_reg;
								sda_bit <= bit_order_select_i ? tx_data_reg[7] : tx_data_reg[0];
							end else if (rx_stop_request_i) begin
								cg_st <= iss_pkg::CG_IDLE; // see RULE_18
								rx_stopped <= 1'b1;
							end else begin
								cg_st <= iss_pkg::CG_LOW; // see RULE_16
							end
						end else begin
							cg_st <= iss_pkg::CG_LOW;
							cg_cnt <= half_cyc - 1'b1;
							sm_bit <= sm_bit + 3'h1;
							sda_bit <= bit_order_select_i ? shift_reg[7] : shift_reg[0]; // see RULE_09
						end
					end
					default: begin
						cg_st <= iss_pkg::CG_IDLE;
					end
				endcase
			end
		end
	end

	// Clock pin: low for the generator's low phase or a slave hold
	logic scl_low;
	assign scl_low = (cg_st == iss_pkg::CG_LOW) | (slv_active & (slv_st == iss_pkg::SL_HOLD));
	assign scl_o = ~scl_low;
	assign scl_oe_n_o = ~(scl_low | sm_mode); // see RULE_08

	// Data pin: ack on the two-wire bus, push-pull in synchronous transmit
	always_comb begin
		sda_o = 1'b1;
		sda_oe_n_o = 1'b1;
		if (slv_active && slv_st == iss_pkg::SL_ACK && !ack_val) begin
			sda_o = 1'b0; // see RULE_02
			sda_oe_n_o = 1'b0;
		end else if (sync_mode && transmit_select_i) begin
			sda_oe_n_o = 1'b0;
			if (sm_mode && cg_st != iss_pkg::CG_IDLE) begin
				sda_o = sda_bit;
			end else if (ext_mode && link_busy) begin
				sda_o = link_sda;
			end else begin
				sda_o = sda_level_out_i; // see RULE_11
			end
		end
	end

endmodule : iss_top

`default_nettype wire

// >>> tb/iss_assertions.sv
// Port checker for the two-wire and synchronous serial block.
// Assumes one system clock domain and an active-high reset.
`timescale 1ns/10ps
`default_nettype none
module iss_assertions (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic scl_o,
	input wire logic scl_oe_n_o,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic xfer_enable_i,
	input wire logic format_select_i,
	input wire logic master_select_i,
	input wire logic transmit_select_i,
	input wire logic sda_level_out_i,
	input wire logic [3:0] clock_rate_select_i,
	input wire logic tx_write_i,
	input wire logic rx_read_i,
	input wire logic [7:0] rx_data_o,
	input wire logic rx_full_flag_o,
	input wire logic tx_empty_flag_o,
	input wire logic overrun_flag_o,
	input wire logic busy_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Clock pin direction follows master select
	property p_mst_scl;
		xfer_enable_i && format_select_i && master_select_i |-> !scl_oe_n_o;
	endproperty
	a_mst_scl: assert property (p_mst_scl) else $error("clock not driven");
	property p_ext_scl;
		format_select_i && !master_select_i |-> scl_oe_n_o;
	endproperty
	a_ext_scl: assert property (p_ext_scl) else $error("clock driven");
	// Idle data line shows the programmed level
	property p_standby;
		xfer_enable_i && format_select_i && transmit_select_i && !busy_o
			|-> !sda_oe_n_o && sda_o == sda_level_out_i;
	endproperty
	a_standby: assert property (p_standby) else $error("standby level");
	property p_tx_take;
		format_select_i && transmit_select_i && tx_write_i |=> !tx_empty_flag_o;
	endproperty
	a_tx_take: assert property (p_tx_take) else $error("write not taken");
	// Low phase is eight cycles at the fastest rate
	property p_scl_low;
		$fell(scl_o) && format_select_i && master_select_i && clock_rate_select_i == 4'h0
			|-> !scl_o [*8] ##1 scl_o;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("low phase length");
	property p_hold;
		!format_select_i && !master_select_i && !scl_oe_n_o && rx_full_flag_o && !rx_read_i
			|=> !scl_oe_n_o;
	endproperty
	a_hold: assert property (p_hold) else $error("clock hold dropped");
	property p_ovr_keep;
		$rose(overrun_flag_o) |-> $stable(rx_data_o);
	endproperty
	a_ovr_keep: assert property (p_ovr_keep) else $error("data lost on overrun");
	property p_ovr_cause;
		$rose(overrun_flag_o) |-> $past(rx_full_flag_o);
	endproperty
	a_ovr_cause: assert property (p_ovr_cause) else $error("spurious overrun");
endmodule : iss_assertions
bind iss_top iss_assertions u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_o(scl_o),
	.scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.xfer_enable_i(xfer_enable_i), .format_select_i(format_select_i),
	.master_select_i(master_select_i), .transmit_select_i(transmit_select_i),
	.sda_level_out_i(sda_level_out_i), .clock_rate_select_i(clock_rate_select_i),
	.tx_write_i(tx_write_i), .rx_read_i(rx_read_i), .rx_data_o(rx_data_o),
	.rx_full_flag_o(rx_full_flag_o), .tx_empty_flag_o(tx_empty_flag_o),
	.overrun_flag_o(overrun_flag_o), .busy_o(busy_o));
`default_nettype wire

// >>> tb/iss_peer.sv
// Far-side model: two-wire bus master and synchronous serial peer.
// Assumes wired-and lines with pull-ups, resolved by the bench.
`timescale 1ns/10ps
`default_nettype none
module iss_peer (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	logic drv = 1'b0;
	logic [7:0] pb = 8'h00;
	logic [7:0] cap = 8'h00;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Capture on rising clock, as a receiver must
	always @(posedge scl_i) cap <= {cap[6:0], sda_i};
	// Shift out on falling clock only
	always @(negedge scl_i) begin
		if (drv) begin
			sda_o <= pb[7];
			pb <= {pb[6:0], pb[7]};
		end
	end
	task start;
		sda_o = 1'b0;
		#200 scl_o = 1'b0;
	endtask : start
	// Nine clocks; the slave may stretch any low phase
	task xfer(input logic [7:0] b, output logic ack);
		for (int i = 0; i < 9; i++) begin
			sda_o = (i < 8) ? b[7 - i] : 1'b1;
			#200 scl_o = 1'b1;
			wait (scl_i);
			#200 ack = sda_i;
			scl_o = 1'b0;
		end
		#100 sda_o = 1'b1;
	endtask : xfer
	task stop;
		sda_o = 1'b0;
		#200 scl_o = 1'b1;
		#200 sda_o = 1'b1;
		#200;
	endtask : stop
endmodule : iss_peer
`default_nettype wire

// >>> tb/iss_top_bench.sv
// Bench for the two-wire slave receiver and synchronous serial engine.
// Assumes the peer model and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module iss_top_bench;
	logic clk_i = 1'b0;
	logic rst = 1'b1;
	logic en = 1'b0, fmt = 1'b0, master_select = 1'b0, transmit_select = 1'b0, msb = 1'b1, ackl = 1'b0;
	logic stp = 1'b0, sdal = 1'b1, twr = 1'b0, rrd = 1'b0, oclr = 1'b0, run = 1'b0, a;
	logic [7:0] tdat = 8'h00;
	logic [3:0] rate = 4'h0;
	logic [6:0] own = 7'h3a;
	logic scl_o, scl_n, sda_o, sda_n, p_scl, p_sda, rxf, txe, ovr;
	logic [7:0] rxd;
	int miscompares = 0, n_tests = 0, cyc = 0;
	// Open-drain lines with pull-ups
	wire logic scl_w = (scl_n | scl_o) & p_scl;
	wire logic sda_w = (sda_n | sda_o) & p_sda;
	iss_top DUT (.clk_i(clk_i), .sys_rst_i(rst), .ce_i(1'b1), .link_clk_i(scl_w),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_n), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n_o(sda_n), .xfer_enable_i(en), .format_select_i(fmt),
		.master_select_i(master_select), .transmit_select_i(transmit_select), .bit_order_select_i(msb),
		.ack_level_bit_i(ackl), .rx_stop_request_i(stp), .sda_level_out_i(sdal),
		.clock_rate_select_i(rate), .timing_half_select_i(1'b0),
		.timing_alt_select_i(1'b0), .own_addr_i(own), .i2c_master_run_i(run),
		.tx_data_i(tdat), .tx_write_i(twr), .rx_read_i(rrd), .overrun_clear_i(oclr),
		.rx_data_o(rxd), .rx_full_flag_o(rxf), .tx_empty_flag_o(txe),
		.overrun_flag_o(ovr), .busy_o());
	iss_peer P (.scl_i(scl_w), .sda_i(sda_w), .scl_o(p_scl), .sda_o(p_sda));
	initial forever #2 clk_i = ~clk_i;
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	task cyc_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask : cyc_n
	task pulse_rd;
		@(posedge clk_i) rrd <= 1'b1;
		@(posedge clk_i) rrd <= 1'b0;
	endtask : pulse_rd
	task pulse_wr(input logic [7:0] d);
		@(posedge clk_i);
		tdat <= d;
		twr <= 1'b1;
		@(posedge clk_i) twr <= 1'b0;
	endtask : pulse_wr
	task print_verdict;
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// Hang guard, well beyond the expected run
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		cyc_n(16);
		rst <= 1'b0;
		cyc_n(4);
		chk("rx_full", 1'b0, rxf);
		chk("rx_data", 8'h00, rxd);
		en <= 1'b1;
		cyc_n(8);
		#1;
		P.start();
		P.xfer({own, 1'b0}, a);
		chk("addr_ack", 1'b0, a);
		chk("addr_full", 1'b1, rxf);
		chk("addr_data", 8'h74, rxd);
		@(posedge clk_i) ackl <= 1'b1;
		pulse_rd();
		P.xfer(8'hc3, a);
		chk("nack", 1'b1, a);
		chk("data1", 8'hc3, rxd);
		// Late read: the slave must stretch the clock
		fork
			P.xfer(8'h5a, a);
			begin
				cyc_n(1000);
				chk("scl_hold", 1'b0, scl_w);
				pulse_rd();
			end
		join
		chk("data2", 8'h5a, rxd);
		pulse_rd();
		P.stop();
		@(posedge clk_i) fmt <= 1'b1;
		cyc_n(8);
		@(posedge clk_i);
		master_select <= 1'b1;
		transmit_select <= 1'b1;
		sdal <= 1'b0;
		cyc_n(8);
		chk("tx_empty", 1'b1, txe);
		chk("standby", 1'b0, sda_w);
		@(posedge clk_i) sdal <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i) msb <= (k == 0);
			pulse_wr(8'hb1);
			cyc_n(150);
			chk("tx_word", (k == 0) ? 8'hb1 : 8'h8d, P.cap);
			chk("tx_empty2", 1'b1, txe);
		end
		P.pb = 8'h3c;
		P.drv = 1'b1;
		@(posedge clk_i) transmit_select <= 1'b0;
		for (int i = 0; i < 400 && rxf !== 1'b1; i++) @(posedge clk_i);
		chk("rx_word", 8'h3c, rxd);
		cyc_n(150);
		chk("overrun", 1'b1, ovr);
		chk("rx_kept", 8'h3c, rxd);
		@(posedge clk_i) stp <= 1'b1;
		pulse_rd();
		@(posedge clk_i) oclr <= 1'b1;
		@(posedge clk_i) oclr <= 1'b0;
		cyc_n(200);
		// Samples cover both halves of a running clock
		for (int j = 0; j < 4; j++) begin
			cyc_n(3);
			chk("scl_stop", 1'b1, scl_w);
		end
		@(posedge clk_i) fmt <= 1'b0;
		run <= 1'b1;
		P.scl_o = 1'b0;
		cyc_n(100);
		chk("scl_wait", 1'b1, scl_n);
		P.scl_o = 1'b1;
		cyc_n(20);
		chk("scl_resume", 1'b0, scl_n);
		print_verdict();
	end
endmodule : iss_top_bench
`default_nettype wire
